//--- tsps_cfg.svh
// timing constants for the transceiver slot power and reset sequencer
`ifndef TSPS_CFG_SVH
`define TSPS_CFG_SVH

`define TSPS_CLK_HZ        25000000
`define TSPS_FIVE_RAMP_NS  2250000
`define TSPS_GAP_NS        500000
`define TSPS_THREE_RAMP_NS 2000000
`define TSPS_INIT_MS       5000
`define TSPS_SETTLE_MS     500
`define TSPS_CLK_NS        40
// least times round up to whole cycles
`define TSPS_FIVE_RAMP_CYC ((`TSPS_FIVE_RAMP_NS + `TSPS_CLK_NS - 1) / `TSPS_CLK_NS)
`define TSPS_GAP_CYC       ((`TSPS_GAP_NS + `TSPS_CLK_NS - 1) / `TSPS_CLK_NS)
`define TSPS_THREE_RAMP_CYC ((`TSPS_THREE_RAMP_NS + `TSPS_CLK_NS - 1) / `TSPS_CLK_NS)
`define TSPS_MS_CYC        (`TSPS_CLK_HZ / 1000)
`define TSPS_CNT_W         32

`endif

//--- tsps_pkg.sv
// types for the transceiver slot power and reset sequencer
package tsps_pkg;

	typedef enum logic [2:0] {
		TSPS_OFF    = 3'b000,
		TSPS_FIVE   = 3'b001,
		TSPS_GAP    = 3'b010,
		TSPS_RAILS  = 3'b011,
		TSPS_INIT   = 3'b100,
		TSPS_SETTLE = 3'b101,
		TSPS_READY  = 3'b110
	} tsps_state_t;

	typedef struct packed {
		logic five_volt_rail;
		logic three_volt_rail;
		logic adjustable_supply_rail;
	} tsps_rails_t;

endpackage : tsps_pkg

//--- tsps_seq.sv
// transceiver slot power rail and module reset sequencer
//
// Notes on behaviour
// - on power enable, raise the five volt rail first; 2.25 ms ramp.
// - start three volt and adjustable rails together 500 us after five volt.
// - allow two milliseconds ramp for three volt and adjustable rails.
// - drive module reset low when module absent or slot power off.
// - hold reset until module present and slot power both on.
// - wait 5 seconds for module initialisation before releasing reset.
// - after release wait 500 ms more, then flag module ready.
`timescale 1ns/1ps
`include "tsps_cfg.svh"

module tsps_seq #(
	parameter int unsigned INIT_MS   = `TSPS_INIT_MS,
	parameter int unsigned SETTLE_MS = `TSPS_SETTLE_MS,
	parameter int unsigned MS_CYC    = `TSPS_MS_CYC,
	// ramp counts are parameters only so that a bench can shorten them
	parameter int unsigned FIVE_CYC  = `TSPS_FIVE_RAMP_CYC,
	parameter int unsigned GAP_CYC   = `TSPS_GAP_CYC,
	parameter int unsigned RAMP_CYC  = `TSPS_THREE_RAMP_CYC
) (
	input  wire logic            i_core_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_power_en,
	input  wire logic            i_absent,
	output tsps_pkg::tsps_rails_t o_rails,
	output logic                 o_module_rst_n,
	output logic                 o_module_ready
);

	////////////////////////////////////////////////////////////////////////
	// state and timers

	tsps_pkg::tsps_state_t  state;
	tsps_pkg::tsps_state_t  next_state;
	logic                   abort;
	logic                   timer_load;
	logic [`TSPS_CNT_W-1:0] timer_count;
	logic                   timer_done;
	logic                   ms_load;
	logic                   ms_tick;
	logic [15:0]            ms_left;
	logic                   ms_phase;

	// the module is hot-pluggable but rails follow power alone
	assign abort = !i_power_en;

	tsps_timer u_cyc_timer (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_load     (timer_load),
		.i_count    (timer_count),
		.o_done     (timer_done)
	);

	// millisecond prescaler keeps the long counts small
	tsps_timer u_ms_timer (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_load     (ms_load),
		.i_count    (`TSPS_CNT_W'(MS_CYC)),
		.o_done     (ms_tick)
	);

	assign ms_phase = (state == tsps_pkg::TSPS_INIT) || (state == tsps_pkg::TSPS_SETTLE);
	assign ms_load  = (state != next_state) || ms_tick;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state  = state;
		timer_load  = 1'b0;
		timer_count = '0;
		unique case (state)
			tsps_pkg::TSPS_OFF: begin
				if (i_power_en) begin
					next_state  = tsps_pkg::TSPS_FIVE;
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(FIVE_CYC);
				end
			end
			tsps_pkg::TSPS_FIVE: begin
				if (abort) begin
					next_state = tsps_pkg::TSPS_OFF;
				end else if (timer_done) begin
					next_state  = tsps_pkg::TSPS_GAP;
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(GAP_CYC);
				end
			end
			tsps_pkg::TSPS_GAP: begin
				if (abort) begin
					next_state = tsps_pkg::TSPS_OFF;
				end else if (timer_done) begin
					next_state  = tsps_pkg::TSPS_RAILS;
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(RAMP_CYC);
				end
			end
			tsps_pkg::TSPS_RAILS: begin
				if (abort) begin
					next_state = tsps_pkg::TSPS_OFF;
				end else if (i_absent) begin
					// rail wait restarts from insertion, else a late insert never leaves
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(RAMP_CYC);
				end else if (timer_done) begin
					next_state = tsps_pkg::TSPS_INIT;
				end
			end
			tsps_pkg::TSPS_INIT: begin
				if (abort) begin
					next_state = tsps_pkg::TSPS_OFF;
				end else if (i_absent) begin
					next_state  = tsps_pkg::TSPS_RAILS;
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(RAMP_CYC);
				end else if (ms_tick && ms_left == 16'h0001) begin
					next_state = tsps_pkg::TSPS_SETTLE;
				end
			end
			tsps_pkg::TSPS_SETTLE: begin
				if (abort) begin
					next_state = tsps_pkg::TSPS_OFF;
				end else if (i_absent) begin
					next_state  = tsps_pkg::TSPS_RAILS;
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(RAMP_CYC);
				end else if (ms_tick && ms_left == 16'h0001) begin
					next_state = tsps_pkg::TSPS_READY;
				end
			end
			tsps_pkg::TSPS_READY: begin
				if (abort) begin
					next_state = tsps_pkg::TSPS_OFF;
				end else if (i_absent) begin
					next_state  = tsps_pkg::TSPS_RAILS;
					timer_load  = 1'b1;
					timer_count = `TSPS_CNT_W'(RAMP_CYC);
				end
			end
			default: begin
				next_state = tsps_pkg::TSPS_OFF;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= tsps_pkg::TSPS_OFF;
		end else begin
			state <= next_state;
		end
	end

	// milliseconds remaining in the init or settle wait
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ms_left <= 16'h0000;
		end else if (next_state == tsps_pkg::TSPS_INIT && state != tsps_pkg::TSPS_INIT) begin
			ms_left <= 16'(INIT_MS);
		end else if (next_state == tsps_pkg::TSPS_SETTLE && state != tsps_pkg::TSPS_SETTLE) begin
			ms_left <= 16'(SETTLE_MS);
		end else if (ms_phase && ms_tick && ms_left != 16'h0000) begin
			ms_left <= ms_left - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs from flip-flops

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rails <= '0;
		end else begin
			o_rails.five_volt_rail         <= (next_state != tsps_pkg::TSPS_OFF);
			o_rails.three_volt_rail        <= (next_state >= tsps_pkg::TSPS_RAILS);
			o_rails.adjustable_supply_rail <= (next_state >= tsps_pkg::TSPS_RAILS);
		end
	end

	// reset released only after the init wait with module present and power on
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_module_rst_n <= 1'b0;
		end else begin
			o_module_rst_n <= (next_state == tsps_pkg::TSPS_SETTLE)
				|| (next_state == tsps_pkg::TSPS_READY);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_module_ready <= 1'b0;
		end else begin
			o_module_ready <= (next_state == tsps_pkg::TSPS_READY);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	a_absent_holds_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_absent |=> !o_module_rst_n) else $error("reset released while module absent");
	a_power_off_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_power_en |=> !o_module_rst_n && !o_module_ready) else $error("reset off without power");
	a_five_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_rails.three_volt_rail |-> o_rails.five_volt_rail) else $error("three volt before five");
	a_rails_together: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_rails.three_volt_rail == o_rails.adjustable_supply_rail) else $error("rails split");
	a_five_ramp_gap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_rails.five_volt_rail) |-> !o_rails.three_volt_rail [*8]) else $error("gap short");
	a_ready_after_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_module_ready |-> o_module_rst_n) else $error("ready while in reset");
	a_release_settles: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_module_rst_n) |-> !o_module_ready [*8]) else $error("ready too early");
	a_init_before_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_module_rst_n) |-> $past(state) == tsps_pkg::TSPS_INIT) else $error("no init wait");
	a_abort_restart: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(ms_phase && i_absent && i_power_en) |=> state == tsps_pkg::TSPS_RAILS)
		else $error("no restart");
	a_rail_ramp: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_rails.three_volt_rail) |-> o_module_rst_n == 1'b0 [*8]) else $error("ramp skipped");

	c_power_up:   cover property (@(posedge i_core_clk) $rose(o_rails.three_volt_rail));
	c_release:    cover property (@(posedge i_core_clk) $rose(o_module_rst_n));
	c_ready:      cover property (@(posedge i_core_clk) $rose(o_module_ready));
	c_hot_unplug: cover property (@(posedge i_core_clk) ms_phase && i_absent);

endmodule : tsps_seq

//--- tsps_tb.sv
// self-checking bench for the slot power and reset sequencer
`timescale 1ns/1ps

module tb_top;
	typedef struct {logic pwr; logic ins; logic [2:0] rails; logic rst_n;} tsps_row_t;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  power_en = 1'b0;
	logic                  inserted = 1'b0;
	logic                  absent;
	logic                  boot_done;
	logic                  mod_rst_n;
	logic                  mod_ready;
	tsps_pkg::tsps_rails_t rails;
	int                    mismatches = 0;
	int                    cmp_count = 0;
	int                    cyc = 0;
	int                    n;
	// shortened ramps keep the run small; ratios follow the real ramp times
	localparam int         T_FIVE = 90;
	localparam int         T_GAP  = 20;
	localparam int         T_RAMP = 80;
	localparam int         T_MS   = 10;
	tsps_row_t             rows [5] = '{'{1'b0, 1'b1, 3'b000, 1'b0}, '{1'b0, 1'b0, 3'b000, 1'b0},
		'{1'b1, 1'b0, 3'b100, 1'b0}, '{1'b0, 1'b0, 3'b000, 1'b0}, '{1'b1, 1'b1, 3'b100, 1'b0}};

	always #20 clk = ~clk;

	tsps_seq #(.INIT_MS(3), .SETTLE_MS(2), .MS_CYC(T_MS), .FIVE_CYC(T_FIVE),
		.GAP_CYC(T_GAP), .RAMP_CYC(T_RAMP)) i_dut (.i_core_clk(clk),
		.i_rst_n(rst_n), .i_power_en(power_en), .i_absent(absent), .o_rails(rails),
		.o_module_rst_n(mod_rst_n), .o_module_ready(mod_ready));
	tsps_xcvr_model #(.BOOT_CYC(5)) i_xcvr (.i_core_clk(clk), .i_inserted(inserted),
		.i_module_rst_n(mod_rst_n), .o_absent(absent), .o_boot_done(boot_done));
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	task automatic chk_out(input logic [2:0] er, input logic ers, input logic erd);
		cmp_count++;
		if (!(rails === er && mod_rst_n === ers && mod_ready === erd)) begin
			mismatches++;
			$display("BAD %0t outputs %b %b %b", $time, rails, mod_rst_n, mod_ready);
		end
	endtask : chk_out

	task automatic chk_span(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("BAD %0t span %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_span

	// bounded wait, in cycles, for one output to go high
	task automatic wait_high(input int sel, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#1;
			cnt++;
		end while (cnt < 1000 && !((sel == 0) ? rails.three_volt_rail === 1'b1 :
			(sel == 1) ? mod_rst_n === 1'b1 : mod_ready === 1'b1));
	endtask : wait_high

	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			mismatches++;
			$display("BAD %0t run too long", $time);
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		step(1);
		chk_out(3'b000, 1'b0, 1'b0);
		step(6);
		@(posedge clk);
		rst_n <= 1'b1;
		step(2);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			power_en <= rows[i].pwr;
			inserted <= rows[i].ins;
			step(3);
			chk_out(rows[i].rails, rows[i].rst_n, 1'b0);
		end
		$display("table rows done");
		@(posedge clk);
		power_en <= 1'b0;
		step(3);
		@(posedge clk);
		power_en <= 1'b1;
		step(2);
		chk_out(3'b100, 1'b0, 1'b0);
		wait_high(0, n);
		chk_span(n, T_FIVE + T_GAP - 1, T_FIVE + T_GAP);
		chk_out(3'b111, 1'b0, 1'b0);
		wait_high(1, n);
		chk_span(n, T_RAMP + 3 * T_MS, T_RAMP + 3 * T_MS + 2);
		wait_high(2, n);
		chk_span(n, 20, 24);
		cmp_count++;
		if (boot_done !== 1'b1) begin
			mismatches++;
			$display("BAD %0t module not booted at ready", $time);
		end
		$display("power up done");
		@(posedge clk);
		inserted <= 1'b0;
		step(2);
		chk_out(3'b111, 1'b0, 1'b0);
		step(10);
		chk_out(3'b111, 1'b0, 1'b0);
		@(posedge clk);
		inserted <= 1'b1;
		wait_high(1, n);
		chk_span(n, T_RAMP + 3 * T_MS, T_RAMP + 3 * T_MS + 2);
		step(5);
		@(posedge clk);
		power_en <= 1'b0;
		step(2);
		chk_out(3'b000, 1'b0, 1'b0);
		$display("restart and power off done");
		@(posedge clk);
		power_en <= 1'b1;
		step(20);
		@(posedge clk);
		rst_n <= 1'b0;
		step(1);
		chk_out(3'b000, 1'b0, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		step(2);
		chk_out(3'b100, 1'b0, 1'b0);
		$display("mid-run reset done");
		final_report();
	end
endmodule : tb_top

//--- tsps_timer.sv
// loadable down-counter with done flag
`timescale 1ns/1ps
`include "tsps_cfg.svh"

module tsps_timer (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_load,
	input  wire logic [`TSPS_CNT_W-1:0] i_count,
	output logic                        o_done
);

	logic [`TSPS_CNT_W-1:0] remain;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			remain <= '0;
		end else if (i_load) begin
			remain <= i_count;
		end else if (remain != '0) begin
			remain <= remain - 1'b1;
		end
	end

	// done reads the count alone: loads are decoded from done, so no loop
	assign o_done = (remain == `TSPS_CNT_W'(1));

endmodule : tsps_timer

//--- tsps_xcvr_model.sv
// behavioural model of the pluggable transceiver in the slot
`timescale 1ns/1ps

module tsps_xcvr_model #(
	parameter int unsigned BOOT_CYC = 5
) (
	input  wire logic i_core_clk,
	input  wire logic i_inserted,
	input  wire logic i_module_rst_n,
	output logic      o_absent,
	output logic      o_boot_done
);
	int unsigned cnt = 0;
	////////////////////////////////////////////////////////////////////////////////
	// presence pin has a slot pull-up, so an empty slot reads high
	assign o_absent = ~i_inserted;
	// own reset handling restarts on every reset or removal
	always @(posedge i_core_clk) begin
		if (!i_inserted || !i_module_rst_n) begin
			cnt <= 0;
		end else if (cnt < BOOT_CYC) begin
			cnt <= cnt + 1;
		end
	end
	assign o_boot_done = (cnt == BOOT_CYC);
endmodule : tsps_xcvr_model
